// ---- rtl/usb_irq_status.sv ----
// Identification and interrupt source read commands of a USB peripheral
`timescale 1ns/1ps
`default_nettype none

module usb_irq_status
  import usb_irq_status_pkg::*;
#(
  parameter logic [7:0] PART_CODE       = 8'h5a, // Arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h03, // Arbitrary value
  parameter int         FRAME_COUNT     = FRAME_CYCLES
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  // Byte-wide command and data port
  input  wire logic          i_command_write,
  input  wire logic          i_data_read,
  input  wire logic [7:0]    i_write_data,
  output logic      [7:0]    o_read_data,
  // Bus and DMA events
  input  wire usb_event_type i_event,
  // Interrupt enables and request
  input  wire logic [31:0]   i_irq_enable,
  output logic               o_interrupt
);

  state_type state;
  state_type next_state;

  logic [31:0] set_bits;
  logic [31:0] clear_bits;
  logic [31:0] live_word;
  logic        tick;
  logic        wake;

  localparam logic [TIMER_WIDTH-1:0] TICK_LAST = TIMER_WIDTH'(FRAME_COUNT - 1);

  // Next state of the whole block
  always_comb begin
    next_state = state;
    set_bits   = '0;
    clear_bits = '0;
    tick       = (state.timer == TICK_LAST);
    wake       = i_event.frame_seen | i_event.resume_seen | i_event.bus_reset_seen;

    // Free-running pseudo frame timer
    next_state.timer = tick ? '0 : state.timer + 1'b1;

    // Event capture
    set_bits[BIT_ENDPOINT_HI:BIT_ENDPOINT_LO] = i_event.endpoint;
    set_bits[BIT_SHORT_END]   = i_event.short_packet_transfer_end;
    set_bits[BIT_PSEUDO_TICK] = tick;
    set_bits[BIT_FRAME_SEEN]  = i_event.frame_seen;
    set_bits[BIT_DMA_DONE]    = i_event.dma_count_done;
    set_bits[BIT_RESUME]      = i_event.resume_seen;
    set_bits[BIT_BUS_RESET]   = i_event.bus_reset_seen;

    // Bus state tracking
    if (!state.started) begin
      next_state.started         = 1'b1;
      next_state.bus_sleep_state = i_event.bus_idle;
    end else if (wake) begin
      next_state.bus_sleep_state = 1'b0;
      next_state.missed          = '0;
    end else if (tick && !state.bus_sleep_state) begin
      if (state.missed == MISSED_LIMIT) begin
        next_state.bus_sleep_state = 1'b1;
        next_state.missed          = '0;
        set_bits[BIT_SUSPEND]      = 1'b1;
      end else begin
        next_state.missed = state.missed + 1'b1;
      end
    end

    // Live word with the bus state in bit 7
    live_word                = state.flags;
    live_word[BIT_BUS_SLEEP] = state.bus_sleep_state;

    // Command and data phases
    if (i_command_write) begin
      next_state.count = '0;
      case (i_write_data)
        PART_IDENTIFICATION: begin
          next_state.phase = PHASE_ID;
          next_state.shift = {16'h0000, PART_CODE, SILICON_REVISION};
        end
        INTERRUPT_SOURCES: begin
          next_state.phase = PHASE_IRQ;
          next_state.shift = live_word;
          next_state.snap  = state.flags;
        end
        default: begin
          next_state.phase = PHASE_IDLE;
          next_state.shift = '0;
        end
      endcase
    end else if (i_data_read) begin
      next_state.shift = {8'h00, state.shift[31:8]};
      next_state.count = state.count + 1'b1;
      case (state.phase)
        PHASE_ID: begin
          if (state.count == ID_LAST_BYTE) begin
            next_state.phase = PHASE_IDLE;
          end
        end
        PHASE_IRQ: begin
          if (state.count == IRQ_LAST_BYTE) begin
            next_state.phase = PHASE_IDLE;
            clear_bits       = state.snap;
          end
        end
        default: begin
          next_state.count = '0;
        end
      endcase
    end

    // Sticky flags; a new event wins over the read clear
    next_state.flags = ((state.flags & ~clear_bits) | set_bits) & STICKY_MASK;

    // Byte presented on the data port
    next_state.read_data = next_state.shift[7:0];
  end

  // State register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state.phase           <= PHASE_IDLE;
      state.count           <= '0;
      state.shift           <= '0;
      state.snap            <= '0;
      state.flags           <= FLAGS_RESET;
      state.bus_sleep_state <= 1'b0;
      state.missed          <= '0;
      state.timer           <= '0;
      state.started         <= 1'b0;
      state.read_data       <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs
  assign o_read_data = state.read_data;
  assign o_interrupt = |(live_word & i_irq_enable);

endmodule
`default_nettype wire

// ---- rtl/usb_irq_status_pkg.sv ----
// Shared constants and types for the identification and interrupt status block
package usb_irq_status_pkg;

  // Command codes written in the command phase
  localparam logic [7:0] PART_IDENTIFICATION = 8'hb5;
  localparam logic [7:0] INTERRUPT_SOURCES   = 8'hc0;

  // Index of the last byte of each read transaction
  localparam logic [1:0] ID_LAST_BYTE  = 2'h1;
  localparam logic [1:0] IRQ_LAST_BYTE = 2'h3;

  // Interrupt source word field positions
  localparam int BIT_BUS_RESET   = 0;
  localparam int BIT_RESUME      = 1;
  localparam int BIT_SUSPEND     = 2;
  localparam int BIT_DMA_DONE    = 3;
  localparam int BIT_FRAME_SEEN  = 4;
  localparam int BIT_PSEUDO_TICK = 5;
  localparam int BIT_SHORT_END   = 6;
  localparam int BIT_BUS_SLEEP   = 7;
  localparam int BIT_ENDPOINT_LO = 8;
  localparam int BIT_ENDPOINT_HI = 23;

  // Sticky bits; bus state and reserved bits are excluded
  localparam logic [31:0] STICKY_MASK = 32'h00ff_ff7f;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // Pseudo frame timing
  localparam int CLOCK_HZ         = 25_000_000;
  localparam int FRAME_TIME_MS    = 1;
  localparam int FRAME_CYCLES     = CLOCK_HZ / 1000 * FRAME_TIME_MS;
  localparam int TIMER_WIDTH      = 20;
  localparam logic [1:0] MISSED_LIMIT = 2'h2;

  // Read transaction phase
  typedef enum logic [2:0] {
    PHASE_IDLE = 3'b001,
    PHASE_ID   = 3'b010,
    PHASE_IRQ  = 3'b100
  } phase_type;

  // Bus events from the serial engine and DMA
  typedef struct packed {
    logic [15:0] endpoint;
    logic        short_packet_transfer_end;
    logic        dma_count_done;
    logic        frame_seen;
    logic        resume_seen;
    logic        bus_reset_seen;
    logic        bus_idle;
  } usb_event_type;

  // Whole block state
  typedef struct packed {
    phase_type              phase;
    logic [1:0]             count;
    logic [31:0]            shift;
    logic [31:0]            snap;
    logic [31:0]            flags;
    logic                   bus_sleep_state;
    logic [1:0]             missed;
    logic [TIMER_WIDTH-1:0] timer;
    logic                   started;
    logic [7:0]             read_data;
  } state_type;

endpackage

// ---- verification/host_model.sv ----
// Host controller model for the command and data port
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and returned byte
  input wire logic       i_clock,
  input wire logic [7:0] i_read_data,
  // Port drive
  output var logic       o_command_write,
  output var logic       o_data_read,
  output var logic [7:0] o_write_data
);
  // Idle port
  initial begin
    o_command_write = 1'b0;
    o_data_read = 1'b0;
    o_write_data = 8'h00;
  end
  // Command phase, then always four reads, low byte first
  task automatic transfer(input logic [7:0] code, output logic [31:0] word);
    @(posedge i_clock) #1 o_command_write = 1'b1;
    o_write_data = code;
    @(posedge i_clock) #1 o_command_write = 1'b0;
    o_write_data = ~code;
    for (int i = 0; i < 4; i++) begin
      word[i*8 +: 8] = i_read_data;
      o_data_read = 1'b1;
      @(posedge i_clock) #1;
    end
    o_data_read = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/irq_props.sv ----
// Port checker for the status block, bound below
`timescale 1ns/1ps
`default_nettype none
module irq_props
  import usb_irq_status_pkg::*;
#(
  parameter logic [7:0] PART_CODE        = 8'h5a,
  parameter logic [7:0] SILICON_REVISION = 8'h03
) (
  // Watched ports
  input wire logic          i_clock, i_rst, i_command_write, i_data_read, o_interrupt,
  input wire logic [7:0]    i_write_data, o_read_data,
  input wire usb_event_type i_event,
  input wire logic [31:0]   i_irq_enable
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Command taken and plain read
  sequence s_cmd(code); i_command_write && i_write_data == code; endsequence
  sequence s_rd; i_data_read && !i_command_write; endsequence
  // Byte order and fixed content
  property p_id_lo; s_cmd(PART_IDENTIFICATION) |=> o_read_data == SILICON_REVISION; endproperty
  a_id_lo: assert property (p_id_lo) else $error("id low");
  property p_id_hi; s_cmd(PART_IDENTIFICATION) ##1 s_rd |=> o_read_data == PART_CODE; endproperty
  a_id_hi: assert property (p_id_hi) else $error("id high");
  property p_top; s_cmd(INTERRUPT_SOURCES) ##1 s_rd [*3] |=> o_read_data == 8'h00; endproperty
  a_top: assert property (p_top) else $error("top byte");
  property p_bad; s_cmd(8'h00) |=> o_read_data == 8'h00; endproperty
  a_bad: assert property (p_bad) else $error("unknown");
  // Request against enables and events
  property p_mask; i_irq_enable == 32'h0000_0000 |-> !o_interrupt; endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_awake;
    i_event.frame_seen |=> (i_irq_enable == 32'h0000_0080 -> !o_interrupt);
  endproperty
  a_awake: assert property (p_awake) else $error("awake");
  property p_sof; i_event.frame_seen |=> (i_irq_enable[BIT_FRAME_SEEN] -> o_interrupt); endproperty
  a_sof: assert property (p_sof) else $error("frame");
  property p_dma; i_event.dma_count_done |=> (i_irq_enable[BIT_DMA_DONE] -> o_interrupt); endproperty
  a_dma: assert property (p_dma) else $error("dma");
  c_id: cover property (s_cmd(PART_IDENTIFICATION) ##1 s_rd);
  c_src: cover property (s_cmd(INTERRUPT_SOURCES) ##1 s_rd [*4]);
  c_int: cover property ($rose(o_interrupt));
endmodule
bind usb_irq_status irq_props #(.PART_CODE(PART_CODE),
  .SILICON_REVISION(SILICON_REVISION)) chk (.*);
`default_nettype wire

// ---- verification/tb_top.sv ----
// Bench for the status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import usb_irq_status_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, i_command_write, i_data_read, o_interrupt;
  logic [7:0] i_write_data, o_read_data;
  logic [31:0] i_irq_enable = 32'h0000_0080, w;
  usb_event_type i_event = 22'h00_0001;
  int bad_count = 0, n_compared = 0;
  // Clock and parts; identity codes are arbitrary
  always #20 i_clock = ~i_clock;
  usb_irq_status #(.PART_CODE(8'h3c), .SILICON_REVISION(8'h07), .FRAME_COUNT(20)) uut (
    .i_clock, .i_rst, .i_command_write, .i_data_read, .i_write_data, .o_read_data,
    .i_event, .i_irq_enable, .o_interrupt);
  host_model host (.i_clock, .i_read_data(o_read_data), .o_command_write(i_command_write),
    .o_data_read(i_data_read), .o_write_data(i_write_data));
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse(input usb_event_type e);
    @(posedge i_clock) #1 i_event = e;
    @(posedge i_clock) #1 i_event = '0;
  endtask
  // Idle bus at reset, then masking
  task automatic t_reset;
    check("idle", 32'(o_interrupt), 32'h0000_0001);
    @(posedge i_clock) #1 i_irq_enable = '0;
    #1 check("mask", 32'(o_interrupt), 32'h0000_0000);
  endtask
  // Identification with reads past its end, and an unknown code
  task automatic t_id;
    host.transfer(PART_IDENTIFICATION, w);
    check("id", w, 32'h0000_3c07);
    host.transfer(8'h00, w);
    check("unknown", w, 32'h0000_0000);
  endtask
  // All bus and DMA event sources at once, then cleared by a full read
  task automatic t_events;
    @(posedge i_clock) #1 i_irq_enable = 32'h0000_0018;
    pulse(22'h3f_fffe);
    check("enabled", 32'(o_interrupt), 32'h0000_0001);
    host.transfer(INTERRUPT_SOURCES, w);
    check("sources", w & 32'hffff_ffdb, 32'h00ff_ff5b);
    host.transfer(INTERRUPT_SOURCES, w);
    check("cleared", w & 32'hffff_ffdb, 32'h0000_0000);
  endtask
  // Missed frames lead to suspend
  task automatic t_sleep;
    @(posedge i_clock) #1 i_irq_enable = 32'h0000_0080;
    pulse(22'h00_0008);
    check("awake", 32'(o_interrupt), 32'h0000_0000);
    repeat (70) @(posedge i_clock);
    #1 check("asleep", 32'(o_interrupt), 32'h0000_0001);
    host.transfer(INTERRUPT_SOURCES, w);
    check("suspend", w & 32'h0000_00a4, 32'h0000_00a4);
  endtask
  // Reset, scenarios, verdict
  initial begin
    repeat (4) @(posedge i_clock);
    #1 i_rst = 1'b0;
    repeat (2) @(posedge i_clock);
    #1 t_reset();
    t_id();
    t_events();
    t_sleep();
    test_done();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge i_clock);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
